// *** design/ber_pkg.sv ***
// Purpose: shared constants and types of the bit error rate test engine
// Assumes: 32-bit classic Wishbone register bus, one clock
// Notes: 8-bit registers sit in the low byte of a word, upper bits read zero
package ber_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 12'h0e0;
  localparam logic [ADDR_W-1:0] OFS_INTERFACE_CONTROL = 12'h0e4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h0e8;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 12'h0ec;
  localparam logic [ADDR_W-1:0] OFS_INFO = 12'h0f0;
  localparam logic [ADDR_W-1:0] OFS_REP_PATTERN = 12'h0f4;
  localparam logic [ADDR_W-1:0] OFS_REP_LENGTH = 12'h0f8;
  localparam logic [ADDR_W-1:0] OFS_ALT_WORDS = 12'h0fc;
  localparam logic [ADDR_W-1:0] OFS_ALT_COUNT = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_BIT_COUNT_HOLD = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_ERROR_COUNT_HOLD = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_TX_SLOT_SELECT = 12'h10c;
  localparam logic [ADDR_W-1:0] OFS_RX_SLOT_SELECT = 12'h110;
  // Control one fields
  localparam int CTL_FORCE_RESYNCHRONIZE = 0;
  localparam int CTL_LOAD_COUNTS = 1;
  localparam int CTL_PS_LO = 2;
  localparam int CTL_PS_HI = 4;
  localparam int CTL_RX_INV = 5;
  localparam int CTL_TX_INV = 6;
  localparam int CTL_GEN_LOAD = 7;
  // Interface control fields
  localparam int IFC_DIR = 1;
  localparam int IFC_RX_FBIT = 2;
  localparam int IFC_TX_FBIT = 3;
  // Status bits, and event mask bits
  localparam int ST_SYNC_CHG = 0;
  localparam int ST_BIT_ERR = 1;
  localparam int ST_BIT_OVF = 2;
  localparam int ST_ERR_OVF = 3;
  localparam int MSK_SYNC = 0;
  localparam int MSK_ERR = 1;
  localparam int MSK_OVF = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int SYNC_MATCH_COUNT = 32;
  localparam int LOS_ERROR_COUNT = 6;
  localparam int QRSS_ZERO_LIMIT = 14;
  localparam int OCTET_COUNT = 55;
  // Feedback taps, zero-based history positions
  localparam int TAP7_A = 6;
  localparam int TAP7_B = 5;
  localparam int TAP9_A = 8;
  localparam int TAP9_B = 4;
  localparam int TAP11_A = 10;
  localparam int TAP11_B = 8;
  localparam int TAP15_A = 14;
  localparam int TAP15_B = 13;
  localparam int TAP20_A = 19;
  localparam int TAP20_B = 16;
  typedef enum logic [2:0] {
    pat_prbs7, pat_prbs11, pat_prbs15, pat_qrss,
    pat_repeat, pat_alt_word, pat_octet55, pat_prbs9
  } pattern_t;
  typedef enum logic {chk_search, chk_sync} checker_state_t;
endpackage : ber_pkg

// *** design/pattern_source.sv ***
// Purpose: pattern generator shared by the transmit source and receive checker
// Assumes: step marks one active bit; load restarts the pattern
// Notes: track shifts received bits into history so checkers self-align
`timescale 1ns/1ps
module pattern_source #(
  parameter logic [8*ber_pkg::OCTET_COUNT-1:0] OCTET_TABLE = {ber_pkg::OCTET_COUNT{8'h80}}
) (
  input logic clock,
  input logic rst_n,
  input ber_pkg::pattern_t mode,
  input logic step,
  input logic load,
  input logic track,
  input logic slip,
  input logic rx_bit,
  input logic [2:0] bit_pos,
  input logic [31:0] rep_pattern,
  input logic [4:0] rep_len_m1,
  input logic [31:0] alt_words,
  input logic [7:0] alt_count,
  output logic expected
);
  import ber_pkg::*;
  logic [31:0] hist_q;
  logic [3:0] zero_run_q;
  logic [3:0] bit_idx_q;
  logic [7:0] rep_q;
  logic word_sel_q;
  logic [5:0] octet_q;
  logic raw;
  logic [15:0] word;
  logic [7:0] octet_byte;

  assign word = word_sel_q ? alt_words[31:16] : alt_words[15:0];
  assign octet_byte = OCTET_TABLE[8*(OCTET_COUNT-1-int'(octet_q)) +: 8];

  always_comb begin
    unique case (mode)
      pat_prbs7: raw = hist_q[TAP7_A] ^ hist_q[TAP7_B];
      pat_prbs11: raw = hist_q[TAP11_A] ^ hist_q[TAP11_B];
      pat_prbs15: raw = hist_q[TAP15_A] ^ hist_q[TAP15_B];
      pat_qrss: raw = hist_q[TAP20_A] ^ hist_q[TAP20_B];
      pat_repeat: raw = hist_q[rep_len_m1];
      pat_alt_word: raw = word[4'hf - bit_idx_q];
      pat_octet55: raw = octet_byte[3'h7 - bit_pos];
      pat_prbs9: raw = hist_q[TAP9_A] ^ hist_q[TAP9_B];
    endcase
  end

  // Zero limiting only alters the output, the history keeps the raw sequence
  assign expected = raw | ((mode == pat_qrss) &&
                    (zero_run_q == 4'(QRSS_ZERO_LIMIT)));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hist_q <= '1;
      zero_run_q <= 4'h0;
    end else if (load) begin
      hist_q <= (mode == pat_repeat) ? rep_pattern : '1;
      zero_run_q <= 4'h0;
    end else if (step) begin
      hist_q <= {hist_q[30:0], track ? rx_bit : raw};
      zero_run_q <= expected ? 4'h0 : zero_run_q + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx_q <= 4'h0;
      rep_q <= 8'h00;
      word_sel_q <= 1'b0;
    end else if (load) begin
      bit_idx_q <= 4'h0;
      rep_q <= 8'h00;
      word_sel_q <= 1'b0;
    end else if (step && !slip) begin
      bit_idx_q <= bit_idx_q + 4'h1;
      if (bit_idx_q == 4'hf) begin
        if (rep_q == alt_count) begin
          rep_q <= 8'h00;
          word_sel_q <= ~word_sel_q;
        end else begin
          rep_q <= rep_q + 8'h01;
        end
      end
    end
  end

  // Octets follow the slot bit position, so they stay byte aligned
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      octet_q <= 6'h00;
    end else if (load) begin
      octet_q <= 6'h00;
    end else if (step && (slip || bit_pos == 3'h7)) begin
      octet_q <= (octet_q == 6'(OCTET_COUNT - 1)) ? 6'h00 : octet_q + 6'h01;
    end
  end
endmodule : pattern_source

// *** design/bit_error_rate_tester.sv ***
// Purpose: bit error rate test engine with Wishbone registers
// Assumes: framer streams run on clock; bit_en marks one bit of a stream
// Notes: stream outputs are one cycle behind their inputs
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
// Behaviour
// - Generate and check 2^7, 2^11, 2^15 sequences and the quasi-random source.
// - User repetitive pattern of one to thirty-two bits.
// - Two 16-bit words alternate after one to 256 repetitions.
// - Checker keeps a 32-bit bit counter and a 24-bit error counter.
// - Report sync change, bit error and counter overflow events.
// - Sync change and bit error events mask separately; both overflow events share mask bit 2.
// - Interface control bit 1 attaches engine to network or backplane side.
// - Per-slot transmit and receive selects choose the slots carrying the pattern.
// - In T1 mode framing-bit use bits add the framing position.
// - Rising control bit 0 forces resynchronization; host clears it between uses.
// - Rising control bit 1 copies counts to hold registers and clears them.
// - Pattern field bits 2-4 select one of eight patterns.
// - Quasi-random is 2^20-1 with at most fourteen zeros in a row.
// - 55-octet pattern repeats byte aligned in active slots.
// - Pattern code 7 gives a 2^9-1 sequence.
// - Bits 5 and 6 invert received and transmitted test data.
// - Rising control bit 7 loads the generator; host clears it between loads.
// - Checker reports sync after 32 consecutive matching bits.
// - Error overflow flag latches, clears on read, sets only on new overflow.
module bit_error_rate_tester #(
  parameter int unsigned BIT_COUNT_W = 32,
  parameter int unsigned ERR_COUNT_W = 24,
  parameter logic [8*ber_pkg::OCTET_COUNT-1:0] OCTET_TABLE = {ber_pkg::OCTET_COUNT{8'h80}}
) (
  input logic clock,
  input logic nrst,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [ber_pkg::ADDR_W-1:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic t1_mode,
  input logic tx_bit_en,
  input logic [4:0] tx_slot,
  input logic tx_fbit,
  input logic [2:0] tx_bit_pos,
  input logic tx_data_in,
  output logic tx_data_out,
  input logic rx_bit_en,
  input logic [4:0] rx_slot,
  input logic rx_fbit,
  input logic [2:0] rx_bit_pos,
  input logic rx_data_in,
  output logic rx_data_out,
  output logic event_alert
);
  import ber_pkg::*;

  logic rst_meta_q, rst_n;
  logic ack_q;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] ctl_q, ctl_prev_q, ifc_q, mask_q;
  logic [3:0] status_q, ev;
  logic [31:0] rep_pat_q, alt_words_q, tx_sel_q, rx_sel_q;
  logic [4:0] rep_len_q;
  logic [7:0] alt_count_q;
  logic [BIT_COUNT_W-1:0] bit_cnt_q, bit_hold_q;
  logic [ERR_COUNT_W-1:0] err_cnt_q, err_hold_q;
  logic req, wr, rd, status_rd;
  logic force_resynchronize_p, load_counts_p, gen_load_p;
  logic dir_bp, tx_act, rx_act;
  logic gen_step, chk_step, chk_bit, gen_exp, chk_exp, mism;
  logic [2:0] gen_pos, chk_pos;
  pattern_t pat;
  checker_state_t chk_state_q;
  logic in_sync, sync_prev_q, self_sync, chk_track, chk_slip, counting;
  logic [5:0] match_q;
  logic [2:0] los_q;
  logic bit_ovf, err_ovf;
  logic tx_out_q, rx_out_q, alert_q;

  // Reset enters asynchronously, is released through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : lanes

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign status_rd = rd && (wb_adr_i == OFS_STATUS);

  // One wait state; unmapped addresses still ack and read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_CONTROL_ONE: rdata_d[7:0] = ctl_q;
      OFS_INTERFACE_CONTROL: rdata_d[7:0] = ifc_q;
      OFS_STATUS: rdata_d[3:0] = status_q;
      OFS_EVENT_MASK: rdata_d[7:0] = mask_q;
      OFS_INFO: rdata_d[1:0] = {~in_sync, in_sync};
      OFS_REP_PATTERN: rdata_d = rep_pat_q;
      OFS_REP_LENGTH: rdata_d[4:0] = rep_len_q;
      OFS_ALT_WORDS: rdata_d = alt_words_q;
      OFS_ALT_COUNT: rdata_d[7:0] = alt_count_q;
      OFS_BIT_COUNT_HOLD: rdata_d[BIT_COUNT_W-1:0] = bit_hold_q;
      OFS_ERROR_COUNT_HOLD: rdata_d[ERR_COUNT_W-1:0] = err_hold_q;
      OFS_TX_SLOT_SELECT: rdata_d = tx_sel_q;
      OFS_RX_SLOT_SELECT: rdata_d = rx_sel_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= RESET_BYTE;
      ifc_q <= RESET_BYTE;
      mask_q <= RESET_BYTE;
      rep_len_q <= 5'h00;
      alt_count_q <= RESET_BYTE;
      rep_pat_q <= 32'h0000_0000;
      alt_words_q <= 32'h0000_0000;
      tx_sel_q <= 32'h0000_0000;
      rx_sel_q <= 32'h0000_0000;
    end else if (wr) begin
      unique case (wb_adr_i)
        OFS_CONTROL_ONE: if (wb_sel_i[0]) ctl_q <= wb_dat_i[7:0];
        OFS_INTERFACE_CONTROL: if (wb_sel_i[0]) ifc_q <= wb_dat_i[7:0];
        OFS_EVENT_MASK: if (wb_sel_i[0]) mask_q <= wb_dat_i[7:0];
        OFS_REP_LENGTH: if (wb_sel_i[0]) rep_len_q <= wb_dat_i[4:0];
        OFS_ALT_COUNT: if (wb_sel_i[0]) alt_count_q <= wb_dat_i[7:0];
        OFS_REP_PATTERN: rep_pat_q <= lanes(rep_pat_q, wb_dat_i, wb_sel_i);
        OFS_ALT_WORDS: alt_words_q <= lanes(alt_words_q, wb_dat_i, wb_sel_i);
        OFS_TX_SLOT_SELECT: tx_sel_q <= lanes(tx_sel_q, wb_dat_i, wb_sel_i);
        OFS_RX_SLOT_SELECT: rx_sel_q <= lanes(rx_sel_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Previous value of the trigger bits gives one-cycle action pulses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl_prev_q <= RESET_BYTE;
    end else begin
      ctl_prev_q <= ctl_q;
    end
  end
  assign force_resynchronize_p = ctl_q[CTL_FORCE_RESYNCHRONIZE] & ~ctl_prev_q[CTL_FORCE_RESYNCHRONIZE];
  assign load_counts_p = ctl_q[CTL_LOAD_COUNTS] & ~ctl_prev_q[CTL_LOAD_COUNTS];
  assign gen_load_p = ctl_q[CTL_GEN_LOAD] & ~ctl_prev_q[CTL_GEN_LOAD];
  assign pat = pattern_t'(ctl_q[CTL_PS_HI:CTL_PS_LO]);

  // Slot or framing-bit selection per stream; framing slot ignores the slot index
  assign tx_act = tx_bit_en & (tx_fbit ? (t1_mode & ifc_q[IFC_TX_FBIT])
                                       : tx_sel_q[tx_slot]);
  assign rx_act = rx_bit_en & (rx_fbit ? (t1_mode & ifc_q[IFC_RX_FBIT])
                                       : rx_sel_q[rx_slot]);
  // Network side: send on transmit, check receive; backplane side swaps them
  assign dir_bp = ifc_q[IFC_DIR];
  assign gen_step = dir_bp ? rx_act : tx_act;
  assign gen_pos = dir_bp ? rx_bit_pos : tx_bit_pos;
  assign chk_step = dir_bp ? tx_act : rx_act;
  assign chk_pos = dir_bp ? tx_bit_pos : rx_bit_pos;
  assign chk_bit = (dir_bp ? tx_data_in : rx_data_in) ^ ctl_q[CTL_RX_INV];

  pattern_source #(.OCTET_TABLE(OCTET_TABLE)) u_gen (
    .clock(clock), .rst_n(rst_n), .mode(pat), .step(gen_step), .load(gen_load_p),
    .track(1'b0), .slip(1'b0), .rx_bit(1'b0), .bit_pos(gen_pos),
    .rep_pattern(rep_pat_q), .rep_len_m1(rep_len_q), .alt_words(alt_words_q),
    .alt_count(alt_count_q), .expected(gen_exp)
  );

  // Sequences and repeats align by shifting in received bits; others slip
  assign self_sync = (pat != pat_alt_word) && (pat != pat_octet55);
  assign chk_track = !in_sync && self_sync;
  assign chk_slip = !in_sync && !self_sync && mism;

  pattern_source #(.OCTET_TABLE(OCTET_TABLE)) u_chk (
    .clock(clock), .rst_n(rst_n), .mode(pat), .step(chk_step), .load(force_resynchronize_p),
    .track(chk_track), .slip(chk_slip), .rx_bit(chk_bit), .bit_pos(chk_pos),
    .rep_pattern(rep_pat_q), .rep_len_m1(rep_len_q), .alt_words(alt_words_q),
    .alt_count(alt_count_q), .expected(chk_exp)
  );
  assign mism = chk_bit ^ chk_exp;
  assign in_sync = (chk_state_q == chk_sync);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chk_state_q <= chk_search;
      match_q <= 6'h00;
      los_q <= 3'h0;
    end else if (force_resynchronize_p) begin
      chk_state_q <= chk_search;
      match_q <= 6'h00;
      los_q <= 3'h0;
    end else if (chk_step) begin
      unique case (chk_state_q)
        chk_search: begin
          if (mism) begin
            match_q <= 6'h00;
          end else if (match_q == 6'(SYNC_MATCH_COUNT - 1)) begin
            chk_state_q <= chk_sync;
            match_q <= 6'h00;
            los_q <= 3'h0;
          end else begin
            match_q <= match_q + 6'h01;
          end
        end
        chk_sync: begin
          // Sync is dropped only after repeated errors without a clean run
          if (mism) begin
            match_q <= 6'h00;
            if (los_q == 3'(LOS_ERROR_COUNT - 1)) begin
              chk_state_q <= chk_search;
            end else begin
              los_q <= los_q + 3'h1;
            end
          end else if (match_q == 6'(SYNC_MATCH_COUNT - 1)) begin
            match_q <= 6'h00;
            los_q <= 3'h0;
          end else begin
            match_q <= match_q + 6'h01;
          end
        end
      endcase
    end
  end

  assign counting = in_sync && chk_step;
  assign bit_ovf = counting && (&bit_cnt_q);
  assign err_ovf = counting && mism && (&err_cnt_q);

  // Load wins over counting; the bit seen in that cycle is dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= '0;
      err_cnt_q <= '0;
      bit_hold_q <= '0;
      err_hold_q <= '0;
    end else if (load_counts_p) begin
      bit_hold_q <= bit_cnt_q;
      err_hold_q <= err_cnt_q;
      bit_cnt_q <= '0;
      err_cnt_q <= '0;
    end else if (counting) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
      if (mism) begin
        err_cnt_q <= err_cnt_q + 1'b1;
      end
    end
  end

  assign ev[ST_SYNC_CHG] = in_sync ^ sync_prev_q;
  assign ev[ST_BIT_ERR] = counting && mism;
  assign ev[ST_BIT_OVF] = bit_ovf;
  assign ev[ST_ERR_OVF] = err_ovf;

  // Read clears the flags, but an event in the same cycle survives
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_q <= 1'b0;
      status_q <= 4'h0;
      alert_q <= 1'b0;
    end else begin
      sync_prev_q <= in_sync;
      status_q <= (status_q & {4{~status_rd}}) | ev;
      alert_q <= (status_q[ST_SYNC_CHG] & mask_q[MSK_SYNC]) |
                 (status_q[ST_BIT_ERR] & mask_q[MSK_ERR]) |
                 ((status_q[ST_BIT_OVF] | status_q[ST_ERR_OVF]) & mask_q[MSK_OVF]);
    end
  end

  // Unselected bits pass through untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_q <= 1'b0;
      rx_out_q <= 1'b0;
    end else begin
      if (tx_bit_en) begin
        tx_out_q <= (!dir_bp && tx_act) ? gen_exp ^ ctl_q[CTL_TX_INV] : tx_data_in;
      end
      if (rx_bit_en) begin
        rx_out_q <= (dir_bp && rx_act) ? gen_exp ^ ctl_q[CTL_TX_INV] : rx_data_in;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign tx_data_out = tx_out_q;
  assign rx_data_out = rx_out_q;
  assign event_alert = alert_q;

  property p_force_resynchronize;
    @(posedge clock) disable iff (!rst_n)
    force_resynchronize_p |=> !in_sync && match_q == 6'h00;
  endproperty
  a_force_resynchronize: assert property (p_force_resynchronize) else $error("force_resynchronize did not restart search");

  property p_load_counts;
    @(posedge clock) disable iff (!rst_n)
    load_counts_p |=> bit_cnt_q == '0 && bit_hold_q == $past(bit_cnt_q);
  endproperty
  a_load_counts: assert property (p_load_counts) else $error("count load wrong");

  property p_err_count;
    @(posedge clock) disable iff (!rst_n)
    counting && mism && !load_counts_p && !(&err_cnt_q) |=> err_cnt_q == $past(err_cnt_q) + 1'b1;
  endproperty
  a_err_count: assert property (p_err_count) else $error("error not counted");

  property p_err_event;
    @(posedge clock) disable iff (!rst_n)
    counting && mism |=> status_q[ST_BIT_ERR] ##1 (status_q[ST_BIT_ERR] || $past(status_rd));
  endproperty
  a_err_event: assert property (p_err_event) else $error("bit error flag missing");

  property p_err_ovf;
    @(posedge clock) disable iff (!rst_n)
    err_ovf && !load_counts_p |=> status_q[ST_ERR_OVF] && err_cnt_q == '0;
  endproperty
  a_err_ovf: assert property (p_err_ovf) else $error("overflow flag missing");

  property p_masked;
    @(posedge clock) disable iff (!rst_n)
    mask_q[2:0] == 3'h0 |=> !alert_q;
  endproperty
  a_masked: assert property (p_masked) else $error("alert while all masked");

  property p_sync_run;
    @(posedge clock) disable iff (!rst_n)
    $rose(in_sync) |-> $past(chk_step && !mism && match_q == 6'(SYNC_MATCH_COUNT - 1));
  endproperty
  a_sync_run: assert property (p_sync_run) else $error("sync without full match run");

  property p_pass;
    @(posedge clock) disable iff (!rst_n)
    tx_bit_en && (dir_bp || !tx_act) |=> tx_data_out == $past(tx_data_in);
  endproperty
  a_pass: assert property (p_pass) else $error("unselected bit altered");

  property p_idle_hold;
    @(posedge clock) disable iff (!rst_n)
    !chk_step && !load_counts_p |=> $stable(bit_cnt_q) && $stable(err_cnt_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counter moved while idle");
endmodule : bit_error_rate_tester

// *** verif/framer_model.sv ***
// Purpose: framer stand-in driving the slot timing of both bit streams
// Assumes: eight bits per slot, framing bit unused, receive data looped back by the bench
// Notes: slow halves the strobe rate so the engine also sees stalled streams
`timescale 1ns/1ps
module framer_model (
  input logic clock,
  input logic rst_n,
  input logic slow,
  output logic tx_bit_en,
  output logic [4:0] tx_slot,
  output logic [2:0] tx_bit_pos,
  output logic rx_bit_en,
  output logic [4:0] rx_slot,
  output logic [2:0] rx_bit_pos
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit_en <= 1'b0;
      {tx_slot, tx_bit_pos} <= 8'h00;
    end else begin
      tx_bit_en <= slow ? ~tx_bit_en : 1'b1;
      if (tx_bit_en) {tx_slot, tx_bit_pos} <= {tx_slot, tx_bit_pos} + 8'h01;
    end
  end
  // Receive strobe trails transmit by one cycle so each looped bit keeps its own slot position
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) {rx_bit_en, rx_slot, rx_bit_pos} <= 9'h000;
    else {rx_bit_en, rx_slot, rx_bit_pos} <= {tx_bit_en, tx_slot, tx_bit_pos};
  end
endmodule : framer_model

// *** verif/bit_error_rate_tester_tb_top.sv ***
// Purpose: self-checking bench of the bit error rate test engine
// Assumes: receive data is the transmit output looped back
// Notes: outside the backplane run, transmit data is random from a fixed seed
`timescale 1ns/1ps
module bit_error_rate_tester_tb_top;
  import ber_pkg::*;
  logic clock, nrst, cyc, stb, we, ack, slow, t1, fb, din, dout, rout, alert;
  logic tx_en, rx_en, pass_chk, prev_en, last_din, bp, prev_rx_en, last_rin;
  logic [ADDR_W-1:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [31:0] seed = 32'd50277;
  logic [4:0] tx_slot, rx_slot;
  logic [2:0] tx_pos, rx_pos;
  logic [ADDR_W-1:0] regs [6] = '{12'h200, OFS_CONTROL_ONE, OFS_INTERFACE_CONTROL,
    OFS_EVENT_MASK, OFS_REP_PATTERN, OFS_TX_SLOT_SELECT};
  int err_total, samples_checked;
  bit_error_rate_tester uut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .t1_mode(t1), .tx_bit_en(tx_en), .tx_slot(tx_slot), .tx_fbit(fb),
    .tx_bit_pos(tx_pos), .tx_data_in(din), .tx_data_out(dout), .rx_bit_en(rx_en),
    .rx_slot(rx_slot), .rx_fbit(fb), .rx_bit_pos(rx_pos), .rx_data_in(dout),
    .rx_data_out(rout), .event_alert(alert));
  framer_model fm (.clock(clock), .rst_n(nrst), .slow(slow), .tx_bit_en(tx_en),
    .tx_slot(tx_slot), .tx_bit_pos(tx_pos), .rx_bit_en(rx_en), .rx_slot(rx_slot),
    .rx_bit_pos(rx_pos));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("Checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Holds the request until ack is sampled; read data is taken at that same edge
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clock);
    if (n >= 50) begin
      chk("bus ack", 32'h1, 32'h0);
      conclude();
    end
  endtask : wb
  task automatic wait_sync;
    int n;
    n = 0;
    do begin
      wb(1'b0, OFS_INFO, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 1000);
    chk("in sync", 32'h1, {31'h0, rd[0]});
    if (rd[0] !== 1'b1) conclude();
  endtask : wait_sync
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    seed <= xs(seed);
    // Backplane runs loop the generated receive stream into the checked transmit stream
    din <= bp ? rout : seed[0];
  end
  // Unselected bits must leave the stream one cycle later unchanged
  always @(posedge clock) begin
    if (pass_chk && prev_en) chk("passthrough", {31'h0, last_din}, {31'h0, dout});
    if (pass_chk && prev_rx_en) chk("rx pass", {31'h0, last_rin}, {31'h0, rout});
    prev_en <= tx_en;
    last_din <= din;
    prev_rx_en <= rx_en;
    last_rin <= dout;
  end
  initial begin
    {nrst, cyc, stb, we, slow, t1, fb, bp, pass_chk} <= 9'h000;
    adr <= '0;
    wdat <= '0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    wb(1'b1, 12'h200, 32'hff);
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 32'h0);
      chk("reset value", 32'h0, rd);
    end
    wb(1'b1, OFS_INTERFACE_CONTROL, 32'h0);
    wb(1'b1, OFS_TX_SLOT_SELECT, 32'hffffffff);
    wb(1'b1, OFS_RX_SLOT_SELECT, 32'hffffffff);
    wb(1'b1, OFS_EVENT_MASK, 32'h3);
    wb(1'b1, OFS_REP_PATTERN, seed);
    wb(1'b1, OFS_REP_LENGTH, 32'h1f);
    wb(1'b1, OFS_ALT_WORDS, xs(seed));
    for (int p = 0; p < 8; p++) begin
      slow <= p[0];
      wb(1'b1, OFS_CONTROL_ONE, {27'h0, p[2:0], 2'b00});
      wb(1'b1, OFS_CONTROL_ONE, {24'h0, 3'b100, p[2:0], 2'b01});
      wait_sync();
    end
    chk("alert on sync", 32'h1, {31'h0, alert});
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("sync change", 32'h1, {31'h0, rd[ST_SYNC_CHG]});
    repeat (4) @(posedge clock);
    chk("alert cleared", 32'h0, {31'h0, alert});
    wb(1'b1, OFS_CONTROL_ONE, 32'h1e);
    wb(1'b1, OFS_CONTROL_ONE, 32'h1c);
    repeat (200) @(posedge clock);
    wb(1'b1, OFS_CONTROL_ONE, 32'h1e);
    wb(1'b0, OFS_BIT_COUNT_HOLD, 32'h0);
    chk("bits counted", 32'h1, {31'h0, rd != 32'h0});
    wb(1'b0, OFS_ERROR_COUNT_HOLD, 32'h0);
    chk("errors counted", 32'h0, rd);
    wb(1'b1, OFS_CONTROL_ONE, 32'h5c);
    repeat (100) @(posedge clock);
    chk("alert on error", 32'h1, {31'h0, alert});
    wb(1'b1, OFS_EVENT_MASK, 32'h0);
    repeat (4) @(posedge clock);
    chk("alert masked", 32'h0, {31'h0, alert});
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("bit error flag", 32'h1, {31'h0, rd[ST_BIT_ERR]});
    // Receive inversion undoes transmit inversion, so the checker locks again
    wb(1'b1, OFS_CONTROL_ONE, 32'h7d);
    wait_sync();
    wb(1'b1, OFS_TX_SLOT_SELECT, 32'h0);
    wb(1'b1, OFS_CONTROL_ONE, 32'h0);
    pass_chk <= 1'b1;
    repeat (200) @(posedge clock);
    pass_chk <= 1'b0;
    // Backplane side on framing bits only: no slot of the checked stream is selected
    wb(1'b1, OFS_INTERFACE_CONTROL, 32'he);
    {t1, fb, bp, slow} <= 4'b1110;
    wb(1'b1, OFS_CONTROL_ONE, 32'h81);
    wait_sync();
    conclude();
  end
  initial begin
    repeat (100000) @(posedge clock);
    chk("run time", 32'h0, 32'h1);
    conclude();
  end
endmodule : bit_error_rate_tester_tb_top
